// ---- rtl/timer2_pkg.sv ----
package timer2_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on apb)
  // ----------------------------------------------------------------
  localparam logic [11:0] TIMER2_CONTROL_ADDR = 12'h0c8;
  localparam logic [11:0] DOWN_COUNT_ADDR     = 12'h0cc;
  localparam logic [11:0] EVENT_INPUT_ADDR    = 12'h0d0;
  localparam logic [11:0] IRQ_STATUS_ADDR     = 12'h0d4;
  localparam logic [11:0] IRQ_MASK_ADDR       = 12'h0d8;

  // ----------------------------------------------------------------
  // timer2_control field positions
  // ----------------------------------------------------------------
  localparam int OVF_BIT   = 7;
  localparam int EXT_BIT   = 6;
  localparam int RXSEL_BIT = 5;
  localparam int TXSEL_BIT = 4;
  localparam int EXEN_BIT  = 3;
  localparam int RUN_BIT   = 2;
  localparam int CT_BIT    = 1;
  localparam int CPRL_BIT  = 0;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET     = 2'h0;

  // irq status / mask layout
  localparam int IRQ_EXT_BIT = 0;
  localparam int IRQ_OVF_BIT = 1;

  typedef struct packed {
    logic timer_overflow_flag;
    logic external_event_flag;
    logic receive_baud_select;
    logic transmit_baud_select;
    logic external_trigger_enable;
    logic timer_run;
    logic counter_timer_select;
    logic capture_reload_select;
  } control_t;

  typedef struct packed {
    logic rx_from_timer2;
    logic tx_from_timer2;
    logic baud_gen_mode;
    logic count_down;
    logic capture_mode;
  } mode_t;

endpackage

// ---- rtl/fall_detect.sv ----
`timescale 1ns/10ps
module fall_detect (
  input  wire logic pclk,     // system clock
  input  wire logic presetn,  // async reset, active low
  input  wire logic level,    // synchronous input level
  output logic      fall      // one-cycle pulse on high-to-low
);
  logic prev_q;

  // reset high, so a pin held low at reset is seen as an edge in the first cycle after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= level;
    end
  end

  assign fall = prev_q & ~level;
endmodule

// ---- rtl/timer2_control_flags.sv ----
// The APB register port is this design's own decision.
`timescale 1ns/10ps
// How it works
// R1 - pin fall edge or count wrap sets external flag per mode bits
// R2 - software writing one to external flag sets it
// R3 - software clears the external flag after a pin-triggered set
// R4 - flag set by pin edge or software raises interrupt if enabled
// R5 - modes 1/3: receive select picks timer1 or this timer, forcing baud mode
// R6 - modes 1/3: transmit select picks timer1 or this timer, forcing baud mode
// R7 - down-count enable sets count direction in 16-bit auto-reload
module timer2_control_flags (
  input  wire logic         pclk,                 // system clock, 50 MHz
  input  wire logic         presetn,              // async reset, active low
  input  wire logic         psel,                 // apb select
  input  wire logic         penable,              // apb enable
  input  wire logic         pwrite,               // apb direction
  input  wire logic [11:0]  paddr,                // apb byte address
  input  wire logic [31:0]  pwdata,               // apb write data
  output logic      [31:0]  prdata,               // apb read data
  output logic              pready,               // apb ready
  output logic              pslverr,              // apb error, unmapped address
  input  wire logic         external_trigger_pin, // external trigger pin
  input  wire logic         timer2_wrap,          // one-cycle wrap pulse of this timer
  input  wire logic         timer1_overflow,      // one-cycle overflow pulse of timer1
  input  wire logic [1:0]   serial_mode,          // serial port mode
  output logic              rx_baud_tick,         // receive baud time base pulse
  output logic              tx_baud_tick,         // transmit baud time base pulse
  output timer2_pkg::mode_t timer_mode,           // mode steering for the counter
  output logic              irq                   // level interrupt
);
  import timer2_pkg::*;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic       setup;
  logic       wr_en;
  logic       hit;
  logic       pin_fall;
  logic       ext_sw_set;
  logic       ext_hw_set;
  logic       ext_set;
  logic       ext_clr;
  logic       ovf_set;
  logic       baud_mode;
  logic       uart_async;
  logic       ext_irq_evt;
  logic [7:0] wbyte;

  control_t   ctrl_q;
  logic       down_count_enable_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == TIMER2_CONTROL_ADDR) || (a == DOWN_COUNT_ADDR) ||
             (a == EVENT_INPUT_ADDR) || (a == IRQ_STATUS_ADDR) ||
             (a == IRQ_MASK_ADDR);
  endfunction

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite & mapped(paddr);
  assign hit   = mapped(paddr);
  assign wbyte = pwdata[7:0];

  // no wait state: ready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      if (paddr == TIMER2_CONTROL_ADDR) begin
        prdata <= {24'h00_0000, ctrl_q};
      end else if (paddr == DOWN_COUNT_ADDR) begin
        prdata <= {31'h0000_0000, down_count_enable_q};
      end else if (paddr == EVENT_INPUT_ADDR) begin
        prdata <= {31'h0000_0000, external_trigger_pin};
      end else if (paddr == IRQ_STATUS_ADDR) begin
        prdata <= {30'h0000_0000, irq_status_q};
      end else if (paddr == IRQ_MASK_ADDR) begin
        prdata <= {30'h0000_0000, irq_mask_q};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode derivation
  // ----------------------------------------------------------------
  assign uart_async = (serial_mode == 2'd1) || (serial_mode == 2'd3);
  assign baud_mode  = ctrl_q.receive_baud_select | ctrl_q.transmit_baud_select; // R5 R6

  fall_detect u_fall (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (external_trigger_pin),
    .fall    (pin_fall)
  );

  // pin edges count only while enabled and not making baud clocks
  assign ext_hw_set = (ctrl_q.external_trigger_enable & ~baud_mode & pin_fall) |
                      (down_count_enable_q & ~ctrl_q.capture_reload_select &
                       ~baud_mode & timer2_wrap); // R1
  assign ext_sw_set = wr_en && paddr == TIMER2_CONTROL_ADDR && wbyte[EXT_BIT]; // R2
  assign ext_set    = ext_hw_set | ext_sw_set;
  assign ext_clr    = wr_en && paddr == TIMER2_CONTROL_ADDR && !wbyte[EXT_BIT]; // R3
  // wrap sets the external flag in up/down mode but raises only the overflow interrupt event
  assign ext_irq_evt = (ctrl_q.external_trigger_enable & ~baud_mode & pin_fall) |
                       ext_sw_set; // R4
  assign ovf_set    = timer2_wrap & ~baud_mode;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= control_t'(CONTROL_RESET);
    end else begin
      if (wr_en && paddr == TIMER2_CONTROL_ADDR) begin
        ctrl_q.receive_baud_select     <= wbyte[RXSEL_BIT];
        ctrl_q.transmit_baud_select    <= wbyte[TXSEL_BIT];
        ctrl_q.external_trigger_enable <= wbyte[EXEN_BIT];
        ctrl_q.timer_run               <= wbyte[RUN_BIT];
        ctrl_q.counter_timer_select    <= wbyte[CT_BIT];
        ctrl_q.capture_reload_select   <= wbyte[CPRL_BIT];
      end
      // set wins over a simultaneous software clear
      if (ext_set) begin
        ctrl_q.external_event_flag <= 1'b1; // R1 R2
      end else if (ext_clr) begin
        ctrl_q.external_event_flag <= 1'b0; // R3
      end
      if (ovf_set) begin
        ctrl_q.timer_overflow_flag <= 1'b1;
      end else if (wr_en && paddr == TIMER2_CONTROL_ADDR) begin
        ctrl_q.timer_overflow_flag <= wbyte[OVF_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      down_count_enable_q <= 1'b0;
    end else if (wr_en && paddr == DOWN_COUNT_ADDR) begin
      down_count_enable_q <= wbyte[0];
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= IRQ_RESET;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == IRQ_EXT_BIT && ext_irq_evt) || (i == IRQ_OVF_BIT && ovf_set)) begin
          irq_status_q[i] <= 1'b1; // R4
        end else if (wr_en && paddr == IRQ_STATUS_ADDR && wbyte[i]) begin
          irq_status_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= IRQ_RESET;
    end else if (wr_en && paddr == IRQ_MASK_ADDR) begin
      irq_mask_q <= wbyte[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_q & irq_mask_q); // R4
    end
  end

  // ----------------------------------------------------------------
  // baud time base and mode outputs
  // ----------------------------------------------------------------
  // registered, so ticks lag the overflow pulses by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_baud_tick <= 1'b0;
      tx_baud_tick <= 1'b0;
      timer_mode   <= '0;
    end else begin
      rx_baud_tick <= (uart_async && ctrl_q.receive_baud_select) ?
                      timer2_wrap : timer1_overflow; // R5
      tx_baud_tick <= (uart_async && ctrl_q.transmit_baud_select) ?
                      timer2_wrap : timer1_overflow; // R6
      timer_mode.rx_from_timer2 <= uart_async & ctrl_q.receive_baud_select;
      timer_mode.tx_from_timer2 <= uart_async & ctrl_q.transmit_baud_select;
      timer_mode.baud_gen_mode  <= baud_mode; // R5 R6
      // baud mode forces auto-reload and ignores capture select
      timer_mode.capture_mode   <= ctrl_q.capture_reload_select & ~baud_mode;
      timer_mode.count_down     <= down_count_enable_q & ~ctrl_q.capture_reload_select &
                                   ~baud_mode; // R7
    end
  end
endmodule

// ---- bench/link_partner.sv ----
`timescale 1ns/10ps
// ----
// trigger pin source and baud consumer
// ----
module link_partner (
  input  wire logic pclk,    // system clock
  input  wire logic rx_tick, // receive baud pulse
  input  wire logic tx_tick, // transmit baud pulse
  output logic      pin,     // trigger pin level
  output logic      t2_wrap, // timer2 wrap pulse
  output logic      t1_ovf   // timer1 overflow pulse
);
  int n_rx = 0;
  int n_tx = 0;
  initial pin = 1'b1;
  initial t2_wrap = 1'b0;
  initial t1_ovf = 1'b0;
  always @(posedge pclk) begin
    n_rx <= n_rx + rx_tick;
    n_tx <= n_tx + tx_tick;
  end
  // 0 pin fall, 1 timer2 wrap, 2 timer1 overflow; pin held low a while
  task automatic pulse(input int which);
    @(posedge pclk);
    case (which)
      0: pin <= 1'b0;
      1: t2_wrap <= 1'b1;
      default: t1_ovf <= 1'b1;
    endcase
    @(posedge pclk);
    t2_wrap <= 1'b0;
    t1_ovf <= 1'b0;
    repeat (3) @(posedge pclk);
    pin <= 1'b1;
  endtask
endmodule

// ---- bench/timer2_control_flags_props.sv ----
`timescale 1ns/10ps
module timer2_control_flags_props (
  input wire logic              pclk,                 // clock
  input wire logic              presetn,              // reset
  input wire logic              psel,                 // select
  input wire logic              penable,              // enable
  input wire logic              pready,               // ready
  input wire logic              pslverr,              // error
  input wire logic              timer2_wrap,          // wrap
  input wire logic              timer1_overflow,      // t1 ovf
  input wire logic [1:0]        serial_mode,          // mode
  input wire logic              rx_baud_tick,         // rx tick
  input wire logic              tx_baud_tick,         // tx tick
  input wire timer2_pkg::mode_t timer_mode            // steering
);
  import timer2_pkg::*;
  // ----
  // apb and baud source checks
  // ----
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer in access cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_rx_timer2: assert property
    (serial_mode[0] && timer_mode.rx_from_timer2 && timer2_wrap |=> rx_baud_tick)
    else $error("rx tick missing from timer2");
  chk_rx_timer1: assert property
    (serial_mode[0] && !timer_mode.rx_from_timer2 && timer1_overflow |=> rx_baud_tick)
    else $error("rx tick missing from timer1");
  chk_tx_timer2: assert property
    (serial_mode[0] && timer_mode.tx_from_timer2 && timer2_wrap |=> tx_baud_tick)
    else $error("tx tick missing from timer2");
  chk_tx_timer1: assert property
    (serial_mode[0] && !timer_mode.tx_from_timer2 && timer1_overflow |=> tx_baud_tick)
    else $error("tx tick missing from timer1");
  chk_rx_quiet: assert property
    (serial_mode[0] && !timer2_wrap && !timer1_overflow |=> !rx_baud_tick)
    else $error("rx tick without source");
  chk_baud_forced: assert property
    (timer_mode.rx_from_timer2 || timer_mode.tx_from_timer2 |-> timer_mode.baud_gen_mode)
    else $error("baud mode not forced");
  cover property (pslverr);
  cover property (rx_baud_tick && timer_mode.rx_from_timer2);
  cover property (tx_baud_tick && !timer_mode.tx_from_timer2);
endmodule
bind timer2_control_flags timer2_control_flags_props props_i (.pclk, .presetn, .psel,
  .penable, .pready, .pslverr, .timer2_wrap, .timer1_overflow, .serial_mode,
  .rx_baud_tick, .tx_baud_tick, .timer_mode);

// ---- bench/timer2_control_flags_test.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module timer2_control_flags_test;
  import timer2_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic pready, pslverr, rerr, pin, wrap, t1, rxt, txt, irq;
  logic [1:0] smode = 2'h1;
  mode_t tmode;
  int err_total = 0, n_compared = 0, cyc = 0, r0, t0;
  timer2_control_flags timer2_control_flags_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .external_trigger_pin(pin),
    .timer2_wrap(wrap), .timer1_overflow(t1), .serial_mode(smode),
    .rx_baud_tick(rxt), .tx_baud_tick(txt), .timer_mode(tmode), .irq);
  link_partner link_partner_i (.pclk, .rx_tick(rxt), .tx_tick(txt), .pin,
    .t2_wrap(wrap), .t1_ovf(t1));
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    // one idle edge first, so a release and the next request never share a time step
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("read data", e, rdat)
  endtask
  task automatic report_and_stop();
    $display("compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(TIMER2_CONTROL_ADDR, {24'h0, CONTROL_RESET});
    rd(EVENT_INPUT_ADDR, 32'h0000_0001);
    rd(12'h0e0, 32'h0000_0000);
    `CHK("slverr", 1'b1, rerr)
    apb(1'b1, IRQ_MASK_ADDR, 32'h0000_0001);
    apb(1'b1, TIMER2_CONTROL_ADDR, 32'h0000_0040);
    rd(TIMER2_CONTROL_ADDR, 32'h0000_0040);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, TIMER2_CONTROL_ADDR, 32'h0000_0000);
    apb(1'b1, IRQ_STATUS_ADDR, 32'h0000_0003);
    link_partner_i.pulse(0);
    rd(TIMER2_CONTROL_ADDR, 32'h0000_0000);
    `CHK("irq", 1'b0, irq)
    apb(1'b1, TIMER2_CONTROL_ADDR, 32'h0000_0008);
    link_partner_i.pulse(0);
    rd(TIMER2_CONTROL_ADDR, 32'h0000_0048);
    rd(IRQ_STATUS_ADDR, 32'h0000_0001);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, TIMER2_CONTROL_ADDR, 32'h0000_0000);
    apb(1'b1, IRQ_STATUS_ADDR, 32'h0000_0003);
    apb(1'b1, DOWN_COUNT_ADDR, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    `CHK("count down", 1'b1, tmode.count_down)
    link_partner_i.pulse(1);
    rd(TIMER2_CONTROL_ADDR, 32'h0000_00c0);
    rd(IRQ_STATUS_ADDR, 32'h0000_0002);
    apb(1'b1, DOWN_COUNT_ADDR, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    `CHK("count down", 1'b0, tmode.count_down)
    apb(1'b1, TIMER2_CONTROL_ADDR, 32'h0000_0000);
    for (int m = 1; m < 4; m += 2) begin
      for (int s = 0; s < 4; s++) begin
        smode <= m[1:0];
        apb(1'b1, TIMER2_CONTROL_ADDR, s << 4);
        // mode outputs are registered one cycle behind the control register
        repeat (2) @(posedge pclk);
        `CHK("baud mode", s != 0, tmode.baud_gen_mode)
        r0 = link_partner_i.n_rx;
        t0 = link_partner_i.n_tx;
        link_partner_i.pulse(1);
        `CHK("rx from t2", r0 + s[1], link_partner_i.n_rx)
        `CHK("tx from t2", t0 + s[0], link_partner_i.n_tx)
        link_partner_i.pulse(2);
        `CHK("rx from t1", r0 + 1, link_partner_i.n_rx)
        `CHK("tx from t1", t0 + 1, link_partner_i.n_tx)
      end
    end
    report_and_stop();
  end
endmodule
